/* timer16_pkg.sv */
// Register map, field positions and codes shared by the dual 16-bit timer block
package timer16_pkg;

  // ********************************************************************
  // Register offsets (byte addresses on the register bus)
  // ********************************************************************
  localparam logic [7:0] RUN_ADDR = 8'h00;
  localparam logic [2:0] CH0_PAGE = 3'h1;   // Timer 0 occupies 0x20..0x3C
  localparam logic [2:0] CH1_PAGE = 3'h2;   // Timer 1 occupies 0x40..0x5C
  localparam logic [4:0] MODE_OFF = 5'h00;
  localparam logic [4:0] FFCTL_OFF = 5'h04;
  localparam logic [4:0] CMPA_OFF = 5'h08;
  localparam logic [4:0] CMPB_OFF = 5'h0c;
  localparam logic [4:0] CAPA_OFF = 5'h10;
  localparam logic [4:0] CAPB_OFF = 5'h14;
  localparam logic [4:0] CTRL2_OFF = 5'h18;
  localparam logic [4:0] COUNT_OFF = 5'h1c;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int RUN_PRE_BIT = 7;
  localparam int MODE_CLK_LSB = 0;
  localparam int MODE_CLE_BIT = 2;
  localparam int MODE_CAPM_LSB = 3;
  localparam int MODE_SWCAP_BIT = 5;
  localparam int FF_CMD_LSB = 0;
  localparam int FF_INV_LSB = 2;     // match a, match b, capture a, capture b
  localparam int FF_AUXCMD_LSB = 6;
  localparam int FF_AUXEN_LSB = 8;   // aux on match b, aux on capture b
  localparam int CTRL2_DB_BIT = 0;
  localparam int CTRL2_OUT_BIT = 1;
  localparam int CTRL2_AUXOUT_BIT = 2;
  localparam int CTRL2_FF_BIT = 8;
  localparam int CTRL2_AUXFF_BIT = 9;

  // ********************************************************************
  // Codes and reset values
  // ********************************************************************
  localparam logic [1:0] CMD_INVERT = 2'h0;
  localparam logic [1:0] CMD_SET = 2'h1;
  localparam logic [1:0] CMD_CLEAR = 2'h2;
  localparam logic [1:0] CMD_NONE = 2'h3;
  localparam logic [1:0] CLK_EXT = 2'h0;
  localparam logic [1:0] CLK_T1 = 2'h1;
  localparam logic [1:0] CLK_T4 = 2'h2;
  localparam logic [1:0] CLK_T16 = 2'h3;
  localparam logic [1:0] CAPM_OFF = 2'h0;
  localparam logic [1:0] CAPM_RISE_AB = 2'h1;
  localparam logic [1:0] CAPM_BOTH_A = 2'h2;
  localparam logic [1:0] CAPM_EIGHT_BIT_TIMER_FF = 2'h3;
  localparam logic [3:0] T4_SUB_LAST = 4'h3;
  localparam logic [3:0] T16_SUB_LAST = 4'hf;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : timer16_pkg

/* edge_sync.sv */
// Two-stage pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ns
module edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } state_type;

  state_type s_reg;
  state_type s_next;

  // Only the second stage feeds the edge logic, never the first
  always_comb begin
    s_next = s_reg;
    s_next.meta = pin;
    s_next.sync = s_reg.meta;
    s_next.prev = s_reg.sync;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Edge pulses last one cycle each
  assign level = s_reg.sync;
  assign rise = s_reg.sync & ~s_reg.prev;
  assign fall = ~s_reg.sync & s_reg.prev;

endmodule : edge_sync

/* timer16_capture_toggle_ppg.sv */
// Dual 16-bit timer/event counter with compare, capture and toggle outputs
//
// Overview of operation
// - Enabled match or capture events invert toggle
// - Command 00 inverts the toggle flip-flop
// - Commands 01 set, 10 clear; reads 11
// - Main toggle drives output pin when enabled
// - Timer 0 adds aux toggle and pin
// - Two timers sharing one prescaler; only timer 0 has aux
// - Match with compare b raises interval interrupt
// - Clear enable resets counter on b match
// - External rising edges count in event mode
// - Writing 0 to capture bit captures count while prescaler runs
// - Buffered compare a loads on b match
// - Mode 01 captures a on rise, interrupts
// - Mode 11 captures on slow flip-flop edges
// - Mode 10 both edges, interrupt on fall
// - Mode 00 performs no hardware captures
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
module timer16_capture_toggle_ppg #(
  parameter int PRESCALE_T1 = 8,
  parameter int PW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [1:0] capture_in_a,
  input wire logic [1:0] capture_in_b,
  input wire logic eight_bit_timer_ff,
  output logic [1:0] toggle_out_pin,
  output logic aux_out_pin,
  output logic [1:0] match_a_irq,
  output logic [1:0] match_b_irq,
  output logic [1:0] edge_irq
);

  // ********************************************************************
  // Elaboration checks
  // ********************************************************************
  generate
    if (PRESCALE_T1 < 2 || PRESCALE_T1 > (1 << PW)) begin : bad_prescale
      $error("PRESCALE_T1 must lie between 2 and 2**PW");
    end
  endgenerate

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [PW-1:0] pre_base;
    logic [3:0] pre_sub;
    logic psc_run;
    logic [1:0] run;
    logic [1:0][1:0] clk_sel;
    logic [1:0] cle;
    logic [1:0][1:0] cap_mode;
    logic [1:0][3:0] inv_en;
    logic [1:0] aux_en;
    logic [1:0] db_en;
    logic [1:0] out_en;
    logic aux_out_en;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] cmp_a;
    logic [1:0][15:0] buf_a;
    logic [1:0][15:0] cmp_b;
    logic [1:0][15:0] cap_a;
    logic [1:0][15:0] cap_b;
    logic [1:0] main_ff;
    logic aux_ff;
    logic eight_bit_timer_ff_prev;
    logic [1:0] irq_ma;
    logic [1:0] irq_mb;
    logic [1:0] irq_edge;
  } state_type;

  state_type s;
  state_type n;

  logic [1:0] rise_a;
  logic [1:0] fall_a;
  logic [1:0] rise_b;
  logic [1:0] cnt_tick;
  logic [1:0] match_a;
  logic [1:0] match_b;
  logic [1:0] ev_ca;
  logic [1:0] ev_cb;
  logic [1:0] sw_cap;
  logic tick_t1;
  logic tick_t4;
  logic tick_t16;
  logic eight_bit_timer_ff_rise;
  logic eight_bit_timer_ff_fall;
  logic wr_done;
  logic [1:0] wr_sel;
  logic [31:0] rd_val;

  // ********************************************************************
  // Helpers
  // ********************************************************************
  // Returns {hit, channel} for a timer page address
  function automatic logic [1:0] decode_chan(input logic [7:0] addr);
    logic [1:0] r;
    r = 2'h0;
    if (addr[7:5] == timer16_pkg::CH0_PAGE) begin
      r = 2'h2;
    end else if (addr[7:5] == timer16_pkg::CH1_PAGE) begin
      r = 2'h3;
    end
    return r;
  endfunction : decode_chan

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // Applies a flip-flop command; the no-op code keeps the value
  function automatic logic apply_cmd(input logic cur, input logic [1:0] cmd);
    logic r;
    r = cur;
    case (cmd)
      timer16_pkg::CMD_INVERT: r = ~cur;
      timer16_pkg::CMD_SET: r = 1'b1;
      timer16_pkg::CMD_CLEAR: r = 1'b0;
      default: r = cur;
    endcase
    return r;
  endfunction : apply_cmd

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  generate
    for (genvar g = 0; g < 2; g++) begin : pins
      edge_sync sync_a (
        .clk(clk),
        .rst(rst),
        .pin(capture_in_a[g]),
        .level(),
        .rise(rise_a[g]),
        .fall(fall_a[g])
      );
      edge_sync sync_b (
        .clk(clk),
        .rst(rst),
        .pin(capture_in_b[g]),
        .level(),
        .rise(rise_b[g]),
        .fall()
      );
    end
  endgenerate

  // ********************************************************************
  // Bus handshake
  // ********************************************************************
  // Every access takes one wait cycle so read data can come from a flop
  assign waitrequest = (read | write) & ~s.ack;
  assign wr_done = write & s.ack;
  assign wr_sel = decode_chan(address);
  assign readdata = s.rdata;

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_val = timer16_pkg::READ_ZERO;
    if (address == timer16_pkg::RUN_ADDR) begin
      rd_val[1:0] = s.run;
      rd_val[timer16_pkg::RUN_PRE_BIT] = s.psc_run;
    end else if (wr_sel[1]) begin
      case (address[4:0])
        timer16_pkg::MODE_OFF: begin
          rd_val[timer16_pkg::MODE_CLK_LSB +: 2] = s.clk_sel[wr_sel[0]];
          rd_val[timer16_pkg::MODE_CLE_BIT] = s.cle[wr_sel[0]];
          rd_val[timer16_pkg::MODE_CAPM_LSB +: 2] = s.cap_mode[wr_sel[0]];
          rd_val[timer16_pkg::MODE_SWCAP_BIT] = 1'b1;
        end
        timer16_pkg::FFCTL_OFF: begin
          rd_val[timer16_pkg::FF_CMD_LSB +: 2] = timer16_pkg::CMD_NONE;
          rd_val[timer16_pkg::FF_INV_LSB +: 4] = s.inv_en[wr_sel[0]];
          rd_val[timer16_pkg::FF_AUXCMD_LSB +: 2] = wr_sel[0] ? 2'h0 : timer16_pkg::CMD_NONE;
          rd_val[timer16_pkg::FF_AUXEN_LSB +: 2] = wr_sel[0] ? 2'h0 : s.aux_en;
        end
        timer16_pkg::CMPA_OFF: rd_val[15:0] = s.cmp_a[wr_sel[0]];
        timer16_pkg::CMPB_OFF: rd_val[15:0] = s.cmp_b[wr_sel[0]];
        timer16_pkg::CAPA_OFF: rd_val[15:0] = s.cap_a[wr_sel[0]];
        timer16_pkg::CAPB_OFF: rd_val[15:0] = s.cap_b[wr_sel[0]];
        timer16_pkg::CTRL2_OFF: begin
          rd_val[timer16_pkg::CTRL2_DB_BIT] = s.db_en[wr_sel[0]];
          rd_val[timer16_pkg::CTRL2_OUT_BIT] = s.out_en[wr_sel[0]];
          rd_val[timer16_pkg::CTRL2_AUXOUT_BIT] = ~wr_sel[0] & s.aux_out_en;
          rd_val[timer16_pkg::CTRL2_FF_BIT] = s.main_ff[wr_sel[0]];
          rd_val[timer16_pkg::CTRL2_AUXFF_BIT] = ~wr_sel[0] & s.aux_ff;
        end
        timer16_pkg::COUNT_OFF: rd_val[15:0] = s.cnt[wr_sel[0]];
        default: rd_val = timer16_pkg::READ_ZERO;
      endcase
    end
  end

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  // Hardware events first, then completed bus writes, so software commands win
  always_comb begin
    n = s;
    n.irq_ma = 2'h0;
    n.irq_mb = 2'h0;
    n.irq_edge = 2'h0;
    n.ack = (read | write) & ~s.ack;
    n.rdata = n.ack ? rd_val : s.rdata;
    // Shared prescaler taps; halted prescaler also stalls software capture
    tick_t1 = s.psc_run && (s.pre_base == PW'(PRESCALE_T1 - 1));
    tick_t4 = tick_t1 && (s.pre_sub[1:0] == timer16_pkg::T4_SUB_LAST[1:0]);
    tick_t16 = tick_t1 && (s.pre_sub == timer16_pkg::T16_SUB_LAST);
    if (!s.psc_run) begin
      n.pre_base = '0;
      n.pre_sub = '0;
    end else begin
      n.pre_base = tick_t1 ? '0 : s.pre_base + 1'b1;
      n.pre_sub = tick_t1 ? s.pre_sub + 1'b1 : s.pre_sub;
    end
    n.eight_bit_timer_ff_prev = eight_bit_timer_ff;
    eight_bit_timer_ff_rise = eight_bit_timer_ff & ~s.eight_bit_timer_ff_prev;
    eight_bit_timer_ff_fall = ~eight_bit_timer_ff & s.eight_bit_timer_ff_prev;
    for (int c = 0; c < 2; c++) begin
      case (s.clk_sel[c])
        timer16_pkg::CLK_EXT: cnt_tick[c] = s.run[c] & rise_a[c];
        timer16_pkg::CLK_T1: cnt_tick[c] = s.run[c] & tick_t1;
        timer16_pkg::CLK_T4: cnt_tick[c] = s.run[c] & tick_t4;
        timer16_pkg::CLK_T16: cnt_tick[c] = s.run[c] & tick_t16;
        default: cnt_tick[c] = 1'b0;
      endcase
      match_a[c] = cnt_tick[c] && (s.cnt[c] == s.cmp_a[c]);
      match_b[c] = cnt_tick[c] && (s.cnt[c] == s.cmp_b[c]);
      // Capture sources per mode
      case (s.cap_mode[c])
        timer16_pkg::CAPM_RISE_AB: begin
          ev_ca[c] = rise_a[c];
          ev_cb[c] = rise_b[c];
        end
        timer16_pkg::CAPM_BOTH_A: begin
          ev_ca[c] = rise_a[c];
          ev_cb[c] = fall_a[c];
        end
        timer16_pkg::CAPM_EIGHT_BIT_TIMER_FF: begin
          ev_ca[c] = eight_bit_timer_ff_rise;
          ev_cb[c] = eight_bit_timer_ff_fall;
        end
        default: begin
          ev_ca[c] = 1'b0;
          ev_cb[c] = 1'b0;
        end
      endcase
      n.irq_edge[c] = (s.cap_mode[c] == timer16_pkg::CAPM_BOTH_A) ? fall_a[c] : rise_a[c];
      n.irq_ma[c] = match_a[c];
      n.irq_mb[c] = match_b[c];
      // Stopped timer holds zero; running counter wraps naturally at 16 bits
      if (!s.run[c]) begin
        n.cnt[c] = timer16_pkg::COUNT_ZERO;
      end else if (cnt_tick[c]) begin
        if (s.cle[c] && match_b[c]) begin
          n.cnt[c] = timer16_pkg::COUNT_ZERO;
        end else begin
          n.cnt[c] = s.cnt[c] + timer16_pkg::COUNT_ONE;
        end
      end
      if (s.db_en[c] && match_b[c]) begin
        n.cmp_a[c] = s.buf_a[c];
      end
      if (ev_ca[c]) begin
        n.cap_a[c] = s.cnt[c];
      end
      if (ev_cb[c]) begin
        n.cap_b[c] = s.cnt[c];
      end
      // One inversion per cycle even if several enabled sources coincide
      if ((match_a[c] & s.inv_en[c][0]) | (match_b[c] & s.inv_en[c][1]) |
          (ev_ca[c] & s.inv_en[c][2]) | (ev_cb[c] & s.inv_en[c][3])) begin
        n.main_ff[c] = ~s.main_ff[c];
      end
      sw_cap[c] = wr_done && wr_sel == {1'b1, c[0]} && address[4:0] == timer16_pkg::MODE_OFF &&
                  byteenable[0] && !writedata[timer16_pkg::MODE_SWCAP_BIT] && s.psc_run;
    end
    // Auxiliary flip-flop exists on timer 0 only
    if ((match_b[0] & s.aux_en[0]) | (ev_cb[0] & s.aux_en[1])) begin
      n.aux_ff = ~s.aux_ff;
    end
    // Completed register writes
    if (wr_done && address == timer16_pkg::RUN_ADDR && byteenable[0]) begin
      n.run = writedata[1:0];
      n.psc_run = writedata[timer16_pkg::RUN_PRE_BIT];
    end
    if (wr_done && wr_sel[1]) begin
      case (address[4:0])
        timer16_pkg::MODE_OFF: begin
          if (byteenable[0]) begin
            n.clk_sel[wr_sel[0]] = writedata[timer16_pkg::MODE_CLK_LSB +: 2];
            n.cle[wr_sel[0]] = writedata[timer16_pkg::MODE_CLE_BIT];
            n.cap_mode[wr_sel[0]] = writedata[timer16_pkg::MODE_CAPM_LSB +: 2];
          end
          if (sw_cap[wr_sel[0]]) begin
            n.cap_a[wr_sel[0]] = s.cnt[wr_sel[0]];
          end
        end
        timer16_pkg::FFCTL_OFF: begin
          if (byteenable[0]) begin
            n.inv_en[wr_sel[0]] = writedata[timer16_pkg::FF_INV_LSB +: 4];
            n.main_ff[wr_sel[0]] = apply_cmd(s.main_ff[wr_sel[0]],
                writedata[timer16_pkg::FF_CMD_LSB +: 2]);
            if (!wr_sel[0]) begin
              n.aux_ff = apply_cmd(s.aux_ff, writedata[timer16_pkg::FF_AUXCMD_LSB +: 2]);
            end
          end
          if (byteenable[1] && !wr_sel[0]) begin
            n.aux_en = writedata[timer16_pkg::FF_AUXEN_LSB +: 2];
          end
        end
        timer16_pkg::CMPA_OFF: begin
          n.buf_a[wr_sel[0]] = merge16(s.buf_a[wr_sel[0]], writedata, byteenable);
          if (!s.db_en[wr_sel[0]]) begin
            n.cmp_a[wr_sel[0]] = merge16(s.cmp_a[wr_sel[0]], writedata, byteenable);
          end
        end
        timer16_pkg::CMPB_OFF: begin
          n.cmp_b[wr_sel[0]] = merge16(s.cmp_b[wr_sel[0]], writedata, byteenable);
        end
        timer16_pkg::CTRL2_OFF: begin
          if (byteenable[0]) begin
            n.db_en[wr_sel[0]] = writedata[timer16_pkg::CTRL2_DB_BIT];
            n.out_en[wr_sel[0]] = writedata[timer16_pkg::CTRL2_OUT_BIT];
            if (!wr_sel[0]) begin
              n.aux_out_en = writedata[timer16_pkg::CTRL2_AUXOUT_BIT];
            end
          end
        end
        default: n.ack = n.ack;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // Pins show zero while not assigned to the timer function
  assign toggle_out_pin = s.out_en & s.main_ff;
  assign aux_out_pin = s.aux_out_en & s.aux_ff;
  assign match_a_irq = s.irq_ma;
  assign match_b_irq = s.irq_mb;
  assign edge_irq = s.irq_edge;

  // ********************************************************************
  // Assertions (timer 0)
  // ********************************************************************
  logic ffctl0_wr;
  assign ffctl0_wr = wr_done && wr_sel == 2'h2 && address[4:0] == timer16_pkg::FFCTL_OFF &&
                     byteenable[0];

  ff_set_cmd_a: assert property (@(posedge clk) disable iff (rst)
    ffctl0_wr && writedata[1:0] == timer16_pkg::CMD_SET |=> toggle_out_pin[0] == s.out_en[0]
    && s.main_ff[0]) else $error("set command did not set the toggle");
  ff_invert_cmd_a: assert property (@(posedge clk) disable iff (rst)
    ffctl0_wr && writedata[1:0] == timer16_pkg::CMD_INVERT |=> s.main_ff[0] != $past(s.main_ff[0]))
    else $error("invert command did not invert the toggle");
  ff_hw_toggle_a: assert property (@(posedge clk) disable iff (rst)
    match_a[0] && s.inv_en[0][0] && !ffctl0_wr |=> s.main_ff[0] != $past(s.main_ff[0]))
    else $error("enabled match did not invert the toggle");
  ffctl_read_a: assert property (@(posedge clk) disable iff (rst)
    read && !waitrequest && wr_sel == 2'h2 && address[4:0] == timer16_pkg::FFCTL_OFF |->
    readdata[1:0] == timer16_pkg::CMD_NONE) else $error("command field did not read 11");
  cnt_wrap_a: assert property (@(posedge clk) disable iff (rst)
    cnt_tick[0] && s.cnt[0] == 16'hffff && !(s.cle[0] && match_b[0]) |=> s.cnt[0] == 16'h0000)
    else $error("counter did not wrap to zero");
  clear_match_a: assert property (@(posedge clk) disable iff (rst)
    cnt_tick[0] && s.cle[0] && match_b[0] |=> s.cnt[0] == 16'h0000 ##1 match_b_irq[0] == 1'b0)
    else $error("counter not cleared on match b");
  match_irq_a: assert property (@(posedge clk) disable iff (rst)
    s.run[0] |=> match_b_irq[0] == $past(match_b[0])) else $error("match b interrupt mistimed");
  event_count_a: assert property (@(posedge clk) disable iff (rst)
    s.run[0] && s.clk_sel[0] == timer16_pkg::CLK_EXT && rise_a[0] && !(s.cle[0] && match_b[0])
    |=> s.cnt[0] == $past(s.cnt[0]) + 16'h0001) else $error("external edge not counted");
  sw_capture_a: assert property (@(posedge clk) disable iff (rst)
    sw_cap[0] |=> s.cap_a[0] == $past(s.cnt[0])) else $error("software capture lost");
  rise_capture_a: assert property (@(posedge clk) disable iff (rst)
    s.cap_mode[0] == timer16_pkg::CAPM_RISE_AB && rise_a[0] && !sw_cap[0] |=>
    s.cap_a[0] == $past(s.cnt[0]) && edge_irq[0]) else $error("mode 01 capture failed");
  fall_irq_a: assert property (@(posedge clk) disable iff (rst)
    s.cap_mode[0] == timer16_pkg::CAPM_BOTH_A |=> edge_irq[0] == $past(fall_a[0]))
    else $error("mode 10 edge interrupt not on falling edge");
  eight_bit_timer_ff_capture_a: assert property (@(posedge clk) disable iff (rst)
    s.cap_mode[0] == timer16_pkg::CAPM_EIGHT_BIT_TIMER_FF && eight_bit_timer_ff_fall |=> s.cap_b[0] == $past(s.cnt[0]))
    else $error("slow flip-flop fall not captured");
  no_capture_a: assert property (@(posedge clk) disable iff (rst)
    s.cap_mode[0] == timer16_pkg::CAPM_OFF |=> $stable(s.cap_b[0]))
    else $error("capture occurred while disabled");
  dbuf_load_a: assert property (@(posedge clk) disable iff (rst)
    s.db_en[0] && match_b[0] && !(wr_done && wr_sel == 2'h2) |=> s.cmp_a[0] == $past(s.buf_a[0]))
    else $error("buffered compare not transferred");

endmodule : timer16_capture_toggle_ppg

/* timer_pin_model.sv */
// Behavioural driver for the external capture and count pins of both timers
`timescale 1ns/1ns
module timer_pin_model (
  input wire logic clk,
  output logic [1:0] capture_in_a,
  output logic [1:0] capture_in_b,
  output logic eight_bit_timer_ff
);
  // Pins idle low; unused sources stay quiet so they cannot fake a capture
  initial begin
    capture_in_a = 2'b00;
    capture_in_b = 2'b00;
    eight_bit_timer_ff = 1'b0;
  end

  // Levels are held several clocks, since the synchroniser drops narrow pulses
  task drive_a(input int ch, input logic v, input int hold);
    @(posedge clk);
    capture_in_a[ch] <= v;
    repeat (hold) @(posedge clk);
  endtask : drive_a

  // The slow flip-flop shares the clock, so it changes right on the edge
  task drive_eight_bit_timer_ff(input logic v, input int hold);
    @(posedge clk);
    eight_bit_timer_ff <= v;
    repeat (hold) @(posedge clk);
  endtask : drive_eight_bit_timer_ff
endmodule : timer_pin_model

/* tb_timer16_capture_toggle_ppg.sv */
// Self-checking bench for the dual 16-bit timer block
`timescale 1ns/1ns
module tb_timer16_capture_toggle_ppg;
  // ******************************************************************
  // Signals, instances and clock
  // ******************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata, q;
  logic waitrequest, eight_bit_timer_ff, aux_out_pin;
  logic [1:0] capture_in_a, capture_in_b, toggle_out_pin, match_a_irq, match_b_irq, edge_irq;
  int err_count = 0;
  int checks = 0;
  int ecnt = 0;
  int mcnt = 0;
  int acnt = 0;
  int fcnt = 0;
  int ff0, fa, k, n, m, e0, cmd, acmd, a0, f0;

  // Short prescale keeps internal ticks cheap; this bench counts on external edges and on T1 ticks
  timer16_capture_toggle_ppg #(.PRESCALE_T1(2)) u_timer16_capture_toggle_ppg (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .capture_in_a(capture_in_a), .capture_in_b(capture_in_b),
    .eight_bit_timer_ff(eight_bit_timer_ff), .toggle_out_pin(toggle_out_pin),
    .aux_out_pin(aux_out_pin), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq),
    .edge_irq(edge_irq));
  timer_pin_model u_timer_pin_model (.clk(clk), .capture_in_a(capture_in_a),
    .capture_in_b(capture_in_b), .eight_bit_timer_ff(eight_bit_timer_ff));

  initial begin
    forever #2 clk = ~clk;
  end

  // Interrupt pulses last one cycle, so they are tallied at every edge
  always @(posedge clk) begin
    if (edge_irq[0] === 1'b1) ecnt <= ecnt + 1;
    if (match_b_irq[1] === 1'b1) mcnt <= mcnt + 1;
    if (match_a_irq[0] === 1'b1) acnt <= acnt + 1;
    if (edge_irq[1] === 1'b1) fcnt <= fcnt + 1;
  end

  // ******************************************************************
  // Tasks and reference model
  // ******************************************************************
  // Request held until waitrequest is sampled low at a rising edge, then released there
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    byteenable <= 4'hf;
    t = 0;
    @(posedge clk);
    while (waitrequest !== 1'b0 && t < 20) begin
      @(posedge clk);
      t++;
    end
    if (t == 20) begin
      err_count++;
      $display("Error %0t bus answer never came", $time);
      tally_and_finish();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task tally_and_finish();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // Command decode: invert, set, clear, leave alone
  function automatic int next_ff(input int c, input int f);
    return (c == 0) ? 1 - f : (c == 1) ? 1 : (c == 2) ? 0 : f;
  endfunction : next_ff

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    void'($urandom(32'hb4f4));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(0, 8'h24, 0);
    chk(q, 32'h0000_00c3);
    bus(0, 8'h44, 0);
    chk(q, 32'h0000_0003);
    bus(0, 8'he0, 0);
    chk(q, timer16_pkg::READ_ZERO);
    $display("test reset values done");
    ff0 = 0;
    fa = 0;
    bus(1, 8'h38, 32'h0000_0006);
    repeat (12) begin
      cmd = $urandom % 4;
      acmd = $urandom % 4;
      bus(1, 8'h24, (acmd << 6) | cmd);
      ff0 = next_ff(cmd, ff0);
      fa = next_ff(acmd, fa);
      repeat (3) @(posedge clk);
      chk(toggle_out_pin[0], ff0);
      chk(aux_out_pin, fa);
    end
    $display("test software commands done");
    // Prescaler kept running so software capture works
    bus(1, 8'h00, 32'h0000_0083);
    bus(1, 8'h24, 32'h0000_00d3);
    for (m = 0; m < 4; m++) begin
      bus(1, 8'h20, 32'h20 | (m << 3));
      // Mode 11: slow flip-flop rises before the pin edge and falls after it
      if (m == 3) begin
        u_timer_pin_model.drive_eight_bit_timer_ff(1'b1, 4);
      end
      e0 = ecnt;
      u_timer_pin_model.drive_a(0, 1'b1, 8);
      chk(ecnt - e0, m != 2);
      e0 = ecnt;
      u_timer_pin_model.drive_a(0, 1'b0, 8);
      chk(ecnt - e0, m == 2);
      if (m == 3) begin
        u_timer_pin_model.drive_eight_bit_timer_ff(1'b0, 4);
      end
      if (m != 0) ff0 = 1 - ff0;
      chk(toggle_out_pin[0], ff0);
      if (m == 0) begin
        bus(0, 8'h30, 0);
        chk(q, 0);
      end
    end
    bus(0, 8'h34, 0);
    chk(q, 4);
    // Count read back through a software capture into capture a
    bus(1, 8'h20, 0);
    bus(0, 8'h30, 0);
    chk(q, 4);
    $display("test capture modes done");
    k = 3 + $urandom % 4;
    n = k + 1 + $urandom % 8;
    bus(1, 8'h48, 1);
    bus(1, 8'h58, 3);
    bus(1, 8'h48, 2);
    bus(0, 8'h48, 0);
    chk(q, 1);
    bus(1, 8'h4c, k);
    bus(1, 8'h44, 32'h0000_000b);
    bus(1, 8'h40, 32'h0000_0024);
    e0 = mcnt;
    f0 = fcnt;
    repeat (n) begin
      u_timer_pin_model.drive_a(1, 1'b1, 4);
      u_timer_pin_model.drive_a(1, 1'b0, 4);
    end
    chk(mcnt - e0, n / (k + 1));
    chk(fcnt - f0, n);
    chk(toggle_out_pin[1], (n / (k + 1)) % 2);
    bus(0, 8'h48, 0);
    chk(q, 2);
    bus(1, 8'h40, 32'h0000_0004);
    bus(0, 8'h50, 0);
    chk(q, n % (k + 1));
    bus(0, 8'h3c, 0);
    chk(q, 4);
    $display("test interval mode done");
    // One-shot on a free-running T1 count: m = 0 toggles on the trigger, m = 1 after a delay
    bus(1, 8'h20, 32'h0000_0029);
    for (m = 0; m < 2; m++) begin
      bus(1, 8'h24, m ? 32'h0000_00c3 : 32'h0000_00d3);
      a0 = acnt;
      u_timer_pin_model.drive_a(0, 1'b1, 8);
      u_timer_pin_model.drive_a(0, 1'b0, 4);
      chk(toggle_out_pin[0], m ? ff0 : 1 - ff0);
      bus(0, 8'h30, 0);
      bus(1, 8'h28, q + 20);
      bus(1, 8'h2c, q + 40 + 20 * m);
      bus(1, 8'h24, m ? 32'h0000_00cf : 32'h0000_00cb);
      k = 0;
      while (match_b_irq[0] !== 1'b1 && k < 300) begin
        @(posedge clk);
        k++;
      end
      if (k == 300) begin
        err_count++;
        $display("Error %0t match b interrupt never came", $time);
        tally_and_finish();
      end
      bus(1, 8'h24, 32'h0000_00c3);
      chk(toggle_out_pin[0], ff0);
      chk(acnt - a0, 1);
    end
    $display("test one-shot pulses done");
    tally_and_finish();
  end
endmodule : tb_timer16_capture_toggle_ppg
